//--- dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------
  // Bench signals and helpers
  // --------------------------
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        pin   = 1'b1;
  logic        droop = 1'b0;
  logic        sub   = 1'b0;
  logic [1:0]  div   = 2'h0;
  logic        cyc, stb, we, ack, shp, drst, pcr, run;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, d;
  logic [7:0]  pdat, pdir;
  int          fails   = 0;
  int          n_tests = 0;
  int          n;
  int          cycles  = 0;

  initial begin
    forever #5 clk = ~clk;
  end
  // Sub clock: period of 8 system clocks
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) sub <= ~sub;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  wdrs_top #(.RELEASE_CY(20), .DROOP_CY(8)) i_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_ext_rst_n_pin(pin), .i_sub_clock(sub), .i_supply_droop(droop),
    .o_shared_port_bit(shp), .o_device_reset(drst), .o_pc_sp_reset(pcr),
    .o_running(run), .o_port_data(pdat), .o_port_dir(pdir));
  wdrs_core i_core (.i_sys_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc),
    .o_stb(stb), .o_we(we), .o_adr(adr), .o_dat(wdat));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [7:0] v);
    i_core.xfer(1'b1, a, v, d);
  endtask
  task automatic rd(input [3:0] a);
    i_core.xfer(1'b0, a, 8'h00, d);
  endtask
  // Bounded wait for a reset output; n is cycles waited
  task automatic wait_ev(input int lim, input bit pc);
    n = 0;
    while (n < lim && (pc ? pcr : drst) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wait_run;
    int k;
    k = 0;
    while (run !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk(run, 1);
  endtask
  task automatic tally_and_finish;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_run();
    rd(4'h0);
    chk(d, 32'h7A);
    rd(4'h4);
    chk(d, 32'h19);
    rd(4'h2);
    chk(d, 32'h0);
    chk({pdat, pdir}, 32'h0000FFFF);
    rd(4'h8);
    chk(d, 32'hE);
    for (int i = 0; i < 3; i++) begin
      wr(4'h4, i == 0 ? 8'h19 : 8'h18);
      wr(4'h0, i == 1 ? 8'h05 : 8'h0A);
      rd(4'h8);
      chk(d[1], i != 2);
    end
    wait_ev(1500, 1'b0);
    chk(n, 1500);
    $display("test enable done");
    wr(4'h4, 8'h19);
    wr(4'h0, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(4'hC, 8'h01);
      wait_ev(700, 1'b0);
      chk(n, 700);
    end
    wait_ev(1200, 1'b0);
    chk(n > 310 && n < 340, 1);
    wait_run();
    rd(4'h8);
    chk(d[0], 1);
    rd(4'h4);
    chk(d, 32'h19);
    $display("test timeout done");
    wr(4'h4, 8'h1B);
    wr(4'h0, 8'h05);
    wr(4'hC, 8'h02);
    wait_ev(600, 1'b0);
    wr(4'hC, 8'h02);
    wait_ev(600, 1'b0);
    chk(n < 600, 1);
    wait_run();
    wr(4'h0, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(4'hC, i[0] ? 8'h02 : 8'h04);
      wait_ev(700, 1'b0);
      chk(n, 700);
    end
    wr(4'hC, 8'h01);
    wait_ev(1100, 1'b0);
    chk(n < 400, 1);
    wait_run();
    $display("test paired done");
    wr(4'h4, 8'h1D);
    wr(4'h0, 8'h05);
    wr(4'hC, 8'h08);
    rd(4'h8);
    chk(d[0], 0);
    wr(4'hC, 8'h10);
    wait_ev(2300, 1'b1);
    chk({drst, n < 2300}, 2'b01);
    rd(4'h8);
    chk(d[0], 1);
    wr(4'h4, 8'h19);
    wr(4'hC, 8'h20);
    wait_ev(1500, 1'b1);
    chk(n, 1500);
    wr(4'hC, 8'h40);
    wr(4'hC, 8'h01);
    $display("test sleep done");
    droop <= 1'b1;
    repeat (5) @(posedge clk);
    droop <= 1'b0;
    wait_ev(40, 1'b0);
    chk(n, 40);
    droop <= 1'b1;
    wait_ev(40, 1'b0);
    chk(n < 40, 1);
    droop <= 1'b0;
    wait_run();
    pin <= 1'b0;
    wait_ev(10, 1'b0);
    chk(n < 10, 1);
    pin <= 1'b1;
    wait_run();
    wr(4'h4, 8'h11);
    pin <= 1'b0;
    wait_ev(10, 1'b0);
    chk({drst, shp}, 2'b00);
    pin <= 1'b1;
    $display("test resets done");
    tally_and_finish();
  end
endmodule // tb

//--- dv/wdrs_checker.sv
module wdrs_checker #(
  parameter PORT_W = 8
) (
  input wire              i_sys_clk,
  input wire              i_rst,
  input wire              i_wb_cyc,
  input wire              i_wb_stb,
  input wire              o_wb_ack,
  input wire              i_ext_rst_n_pin,
  input wire              o_shared_port_bit,
  input wire              o_device_reset,
  input wire              o_pc_sp_reset,
  input wire              o_running,
  input wire [PORT_W-1:0] o_port_data,
  input wire [PORT_W-1:0] o_port_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------
  // Port relations over time
  // -------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_por_state: assert property ($fell(i_rst) |-> o_device_reset && o_pc_sp_reset && !o_running
    && (&o_port_data) && (&o_port_dir)) else $error("power-on state wrong");
  a_release_wait: assert property ($fell(i_rst) |-> !o_running [*8])
    else $error("running before release delay");
  a_run_excl: assert property (o_running |-> !o_device_reset)
    else $error("running during reset");
  a_pc_with_rst: assert property (o_device_reset |-> o_pc_sp_reset)
    else $error("pc not reset with device");
  a_full_rst_ports: assert property (o_device_reset && $past(o_device_reset) |-> &o_port_dir)
    else $error("ports not inputs in reset");
  a_pin_route: assert property (!i_ext_rst_n_pin [*5] |-> o_device_reset || !o_shared_port_bit)
    else $error("low pin neither resets nor shows");
  a_sleep_pulse: assert property ($rose(o_pc_sp_reset) && !o_device_reset |=> !o_pc_sp_reset)
    else $error("sleep timeout pulse too long");
endmodule // wdrs_checker

bind wdrs_top wdrs_checker #(.PORT_W(PORT_W)) i_chk (.*);

//--- dv/wdrs_core.sv
module wdrs_core (
  input  wire         i_sys_clk,
  input  wire         i_ack,
  input  wire  [31:0] i_rdat,
  output logic        o_cyc,
  output logic        o_stb,
  output logic        o_we,
  output logic [3:0]  o_adr,
  output logic [31:0] o_dat
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // Core side: one held bus cycle per instruction
  // ---------------------------------------------
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 4'h0;
    o_dat = 32'h0;
  end

  task automatic xfer(input bit w, input [3:0] a, input [7:0] v, output [31:0] r);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    o_dat <= {24'h0, v};
    @(posedge i_sys_clk);
    while (i_ack !== 1'b1) @(posedge i_sys_clk);
    r = i_rdat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    // Stale data must not look valid
    o_dat <= ~o_dat;
    @(posedge i_sys_clk);
  endtask
endmodule // wdrs_core

//--- hw/wdrs_qual.v
// Holds o_hit while i_level has stood high longer than LIMIT cycles
module wdrs_qual #(
  parameter WIDTH = 16,
  parameter LIMIT = 12000
) (
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_level,
  output reg  o_hit
);
  reg [WIDTH-1:0] count;

  always @(posedge i_sys_clk) begin
    if (i_rst || !i_level) begin
      count <= {WIDTH{1'b0}};
      o_hit <= 1'b0;
    end else if (count < LIMIT[WIDTH-1:0]) begin
      count <= count + 1'b1;
      o_hit <= 1'b0;
    end else begin
      o_hit <= 1'b1;
    end
  end
endmodule // wdrs_qual

//--- hw/wdrs_regs.vh
`ifndef WDRS_REGS_VH
`define WDRS_REGS_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define WDRS_ADR_CTRL      4'h0
`define WDRS_ADR_CONFIG    4'h4
`define WDRS_ADR_STATUS    4'h8
`define WDRS_ADR_CMD       4'hC

// ---------------------------------------------------------------
// Control register layout and reset value
// ---------------------------------------------------------------
`define WDRS_CTRL_KEY_LSB  0
`define WDRS_CTRL_KEY_MSB  3
`define WDRS_CTRL_SEL_LSB  4
`define WDRS_CTRL_SEL_MSB  6
`define WDRS_CTRL_SYSON    7
`define WDRS_CTRL_RST      8'h7A
`define WDRS_KEY_OFF       4'hA

// ---------------------------------------------------------------
// Config register bits
// ---------------------------------------------------------------
`define WDRS_CFG_WDT_EN    0
`define WDRS_CFG_PAIR      1
`define WDRS_CFG_SRC_SUB   2
`define WDRS_CFG_PIN_RST   3
`define WDRS_CFG_DROOP_EN  4
`define WDRS_CFG_THR_LSB   5
`define WDRS_CFG_THR_MSB   7
`define WDRS_CFG_RST       8'h19

// ---------------------------------------------------------------
// Status and command bits
// ---------------------------------------------------------------
`define WDRS_ST_TIMEOUT    0
`define WDRS_ST_ENABLED    1
`define WDRS_ST_PAIR_LAST  2
`define WDRS_ST_RUNNING    3
`define WDRS_CMD_SINGLE    0
`define WDRS_CMD_FIRST     1
`define WDRS_CMD_SECOND    2
`define WDRS_CMD_HALT      3
`define WDRS_CMD_SLEEP     4
`define WDRS_CMD_IDLE_ZERO_MODE     5
`define WDRS_CMD_WAKE      6

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WDRS_CLK_MHZ       100
`define WDRS_RELEASE_MS    100
`define WDRS_DROOP_US      120
`define WDRS_BASE_DIV_LOG2 8

`endif

//--- hw/wdrs_sync.v
module wdrs_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] sync;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta <= {WIDTH{1'b1}};
      sync <= {WIDTH{1'b1}};
    end else begin
      meta <= i_async;
      sync <= meta;
    end
  end

  assign o_sync = sync;
endmodule // wdrs_sync

//--- hw/wdrs_top.v
`include "wdrs_regs.vh"

// Notes on behaviour
// [R1] Counter overflow resets the device unless software cleared it first.
// [R2] Disabled only when option says disable and key equals 1010.
// [R3] Key reads 1010 after power-on.
// [R4] Software should write 0101 to the key when the watchdog is used.
// [R5] While disabled, all watchdog instructions do nothing.
// [R6] Timeout in normal run resets the device and sets the timeout flag.
// [R7] Timeout in sleep or idle sets flag, resets only PC and stack.
// [R8] Reset pin low, valid clear, or halt clears the counter.
// [R9] Option picks single or paired clear; only that scheme clears.
// [R10] Paired scheme clears only on alternating first and second clears.
// [R11] Repeating the same paired clear does nothing.
// [R12] Timeout is source clock divided by 2^8 up to 2^15.
// [R13] System-clock source stops counting in sleep or idle-zero.
// [R14] Power-on reset sets the program counter to zero.
// [R15] Power-on reset sets port data and direction registers to ones.
// [R16] Reset pin shares a port bit; an option selects its use.
// [R17] After pin release, wait the release delay before running.
// [R18] Pin reset keeps some registers; running resumes after release.
// [R19] Supply droop resets only if it lasts beyond the minimum time.
// [R20] Droop reset is a full reset; enable and threshold are options. The threshold bits are not used here; only the enable bit is.
// [R21] Select code 000 gives 256 source clocks, doubling up to 32768.
// [R22] Option picks sub clock or system clock divided by four.
// [R23] Each clear zeroes the counter; paired scheme tracks last clear.
module wdrs_top #(
  parameter CNT_W      = 16,
  parameter PORT_W     = 8,
  parameter REL_W      = 24,
  parameter RELEASE_CY = `WDRS_RELEASE_MS * 1000 * `WDRS_CLK_MHZ,
  parameter DROOP_CY   = `WDRS_DROOP_US * `WDRS_CLK_MHZ
) (
  input  wire              i_sys_clk,
  input  wire              i_rst,
  input  wire              i_wb_cyc,
  input  wire              i_wb_stb,
  input  wire              i_wb_we,
  input  wire [3:0]        i_wb_adr,
  input  wire [3:0]        i_wb_sel,
  input  wire [31:0]       i_wb_dat,
  output reg  [31:0]       o_wb_dat,
  output reg               o_wb_ack,
  input  wire              i_ext_rst_n_pin,
  input  wire              i_sub_clock,
  input  wire              i_supply_droop,
  output wire              o_shared_port_bit,
  output reg               o_device_reset,
  output reg               o_pc_sp_reset,
  output reg               o_running,
  output reg  [PORT_W-1:0] o_port_data,
  output reg  [PORT_W-1:0] o_port_dir
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [2:0] pins_sync;
  wire       pin_level;
  wire       sub_level;
  wire       droop_level;

  wdrs_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_supply_droop, i_sub_clock, i_ext_rst_n_pin}),
    .o_sync    (pins_sync)
  );
  assign pin_level   = pins_sync[0];
  assign sub_level   = pins_sync[1];
  assign droop_level = pins_sync[2];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]       ctrl;
  reg  [7:0]       cfg;
  reg              timeout_flag;
  reg              pair_last;
  reg              in_sleep;
  reg              in_idle_zero_mode;
  reg  [CNT_W-1:0] wdt_count;
  reg  [1:0]       div4;
  reg              sub_prev;
  reg  [REL_W-1:0] rel_count;
  reg              pin_held;

  wire [3:0] wdt_disable_key = ctrl[`WDRS_CTRL_KEY_MSB:`WDRS_CTRL_KEY_LSB];
  wire [2:0] timeout_select  = ctrl[`WDRS_CTRL_SEL_MSB:`WDRS_CTRL_SEL_LSB];
  wire       pin_is_reset    = cfg[`WDRS_CFG_PIN_RST];
  wire       pair_scheme     = cfg[`WDRS_CFG_PAIR];
  wire       src_sub         = cfg[`WDRS_CFG_SRC_SUB];

  // Port bit shows the pin only when it is not the reset function
  assign o_shared_port_bit = pin_is_reset ? 1'b1 : pin_level; // [R16]

  // Disabled only by option plus key together
  wire wdt_on = cfg[`WDRS_CFG_WDT_EN] || (wdt_disable_key != `WDRS_KEY_OFF); // [R2]

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire req      = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wr       = req && i_wb_we && i_wb_sel[0];
  wire wr_ctrl  = wr && (i_wb_adr == `WDRS_ADR_CTRL);
  wire wr_cfg   = wr && (i_wb_adr == `WDRS_ADR_CONFIG);
  wire wr_cmd   = wr && (i_wb_adr == `WDRS_ADR_CMD);
  wire [7:0] op = wr_cmd ? i_wb_dat[7:0] : 8'h00;

  // Clear and halt instructions act only while enabled; sleep, idle and wake act always
  wire op_single = wdt_on && op[`WDRS_CMD_SINGLE]; // [R5]
  wire op_first  = wdt_on && op[`WDRS_CMD_FIRST];  // [R5]
  wire op_second = wdt_on && op[`WDRS_CMD_SECOND]; // [R5]
  wire op_halt   = wdt_on && op[`WDRS_CMD_HALT];   // [R5]

  // Only the chosen scheme clears; paired needs alternation
  wire clr_single = !pair_scheme && op_single;                 // [R9]
  wire clr_first  = pair_scheme && op_first && pair_last;      // [R10] [R11]
  wire clr_second = pair_scheme && op_second && !pair_last;    // [R10] [R11]
  wire pin_low    = pin_is_reset && !pin_level;
  wire wdt_clear  = clr_single || clr_first || clr_second || op_halt || pin_low; // [R8]

  // ---------------------------------------------------------------
  // Watchdog source and counter
  // ---------------------------------------------------------------
  wire sub_tick  = sub_level && !sub_prev;
  wire sys_tick  = (div4 == 2'h3) && !in_sleep && !in_idle_zero_mode;   // [R13]
  wire src_tick  = src_sub ? sub_tick : sys_tick;               // [R22]
  wire [CNT_W:0] period = {{CNT_W{1'b0}}, 1'b1} << (`WDRS_BASE_DIV_LOG2 + timeout_select); // [R12] [R21]
  wire overflow  = wdt_on && src_tick && ({1'b0, wdt_count} == period - 1'b1); // [R1]

  wire droop_hit;
  wdrs_qual #(
    .WIDTH (16),
    .LIMIT (DROOP_CY)
  ) u_droop (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_level   (droop_level && cfg[`WDRS_CFG_DROOP_EN]), // [R19] [R20]
    .o_hit     (droop_hit)
  );

  wire sleeping   = in_sleep || in_idle_zero_mode;
  wire full_reset = pin_low || droop_hit || (overflow && !sleeping); // [R6] [R20]

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      div4      <= 2'h0;
      sub_prev  <= 1'b0;
      wdt_count <= {CNT_W{1'b0}};
      pair_last <= 1'b1;
    end else begin
      div4     <= div4 + 2'h1;
      sub_prev <= sub_level;
      if (wdt_clear || overflow || !wdt_on) begin
        wdt_count <= {CNT_W{1'b0}}; // [R23]
      end else if (src_tick) begin
        wdt_count <= wdt_count + 1'b1;
      end
      if (clr_first) begin
        pair_last <= 1'b0; // [R23]
      end else if (clr_second) begin
        pair_last <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl           <= `WDRS_CTRL_RST;   // [R3]
      cfg            <= `WDRS_CFG_RST;
      timeout_flag   <= 1'b0;
      in_sleep       <= 1'b0;
      in_idle_zero_mode       <= 1'b0;
      rel_count      <= {REL_W{1'b0}};
      pin_held       <= 1'b1;
      o_device_reset <= 1'b1;
      o_pc_sp_reset  <= 1'b1;              // [R14]
      o_running      <= 1'b0;
      o_port_data    <= {PORT_W{1'b1}};    // [R15]
      o_port_dir     <= {PORT_W{1'b1}};    // [R15]
    end else begin
      o_pc_sp_reset <= full_reset || pin_held || (overflow && sleeping); // [R7]
      if (full_reset) begin
        ctrl           <= `WDRS_CTRL_RST;
        o_port_data    <= {PORT_W{1'b1}};
        o_port_dir     <= {PORT_W{1'b1}};
        in_sleep       <= 1'b0;
        in_idle_zero_mode       <= 1'b0;
        pin_held       <= 1'b1;            // [R17]
        rel_count      <= {REL_W{1'b0}};
        o_device_reset <= 1'b1;            // [R1] [R6]
        o_running      <= 1'b0;
      end else if (pin_held) begin
        // Config and flag kept through a pin reset
        if (rel_count >= RELEASE_CY[REL_W-1:0] - 1'b1) begin
          pin_held       <= 1'b0;          // [R17] [R18]
          o_device_reset <= 1'b0;
          o_running      <= 1'b1;
        end else begin
          rel_count <= rel_count + 1'b1;
        end
      end else begin
        if (wr_ctrl) begin
          ctrl <= i_wb_dat[7:0];
        end
        if (wr_cfg) begin
          cfg <= i_wb_dat[7:0];
        end
        if (op[`WDRS_CMD_SLEEP]) begin
          in_sleep <= 1'b1;
        end else if (op[`WDRS_CMD_IDLE_ZERO_MODE]) begin
          in_idle_zero_mode <= 1'b1;
        end else if (op[`WDRS_CMD_WAKE] || (overflow && sleeping)) begin
          in_sleep <= 1'b0;
          in_idle_zero_mode <= 1'b0;
        end
      end
      // Set wins over a halt clear
      if (overflow) begin
        timeout_flag <= 1'b1;              // [R6] [R7]
      end else if (op_halt) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus answer: one wait-free ack, reads of unmapped space give zero
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      if (req && !i_wb_we) begin
        if (i_wb_adr == `WDRS_ADR_CTRL) begin
          o_wb_dat <= {24'h000000, ctrl};
        end else if (i_wb_adr == `WDRS_ADR_CONFIG) begin
          o_wb_dat <= {24'h000000, cfg};
        end else if (i_wb_adr == `WDRS_ADR_STATUS) begin
          o_wb_dat <= {28'h0000000, o_running, pair_last, wdt_on, timeout_flag};
        end else begin
          o_wb_dat <= 32'h00000000;
        end
      end
    end
  end
endmodule // wdrs_top
